// ---- pcgpio_port.sv ----
// What this block does
// R1 - identification upper half returns the device identifier, read only
// R2 - identification lower half returns the silicon revision identifier, read only
// R3 - data bits 15..8 report sampled pin levels, bit n for pin n
// R4 - data bits 7..0 hold output levels, 0 drives low, 1 drives high
// R5 - level writes affect only output pins; input pin bits keep their value
// R6 - reading an output pin's level bit returns the last written value
// R7 - control bits 7..0 set direction, 0 input, 1 output
// R8 - control bits 15..8 select normal or weak pull mode
// R9 - control bits 23..16 select pull down (0) or pull up (1)
// R10 - weak pull active only when mode bit and direction bit are both 1
// R11 - control resets to zero; bits 31..24 reserved, read as zero
// R12 - output levels reset to zero; data bits 31..16 reserved, read only
// R13 - pin inputs pass a two-stage synchroniser before being reported
`timescale 1ns/100ps
module pcgpio_port #(
  // arbitrary identification values, not tied to any real part
  parameter logic [15:0] DEVICE_IDENTIFIER   = 16'h5a01,
  parameter logic [15:0] REVISION_IDENTIFIER = 16'h0001
) (
  input  wire logic        clk_i,
  input  wire logic        reset_n_i,
  input  wire logic [11:0] reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [31:0] reg_wdata_i,
  output logic      [31:0] reg_rdata_o,
  output logic             reg_rvalid_o,
  input  wire logic [7:0]  io_pin_i,
  output logic      [7:0]  io_pin_o,
  output logic      [7:0]  io_pin_oe_o,
  output logic      [7:0]  pull_up_en_o,
  output logic      [7:0]  pull_down_en_o
);

  function automatic logic [7:0] pick_byte(input logic [31:0] word, input int lsb);
    pick_byte = word[lsb +: 8];
  endfunction : pick_byte

  logic        rst_n;
  logic [7:0]  pin_state;
  logic [7:0]  pin_direction_reg;
  logic [7:0]  weak_pull_mode_reg;
  logic [7:0]  pull_direction_reg;
  logic [7:0]  output_level_reg;
  logic [7:0]  output_level_next;
  logic [7:0]  pull_up_next;
  logic [7:0]  pull_down_next;
  logic [31:0] rdata_next;
  logic        hit_id;
  logic        hit_data;
  logic        hit_ctrl;
  logic        wr_data;
  logic        wr_ctrl;
  logic [31:0] id_word;
  logic [31:0] data_word;
  logic [31:0] ctrl_word;

  // reset is asserted at once but released in step with the clock
  pcgpio_sync #(
    .WIDTH (1)
  ) u_reset_sync (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .d_i       (1'b1),
    .q_o       (rst_n)
  );

  // pins are asynchronous to this clock
  pcgpio_sync #(
    .WIDTH (pcgpio_pkg::PIN_COUNT)
  ) u_pin_sync (
    .clk_i     (clk_i),
    .reset_n_i (rst_n),
    .d_i       (io_pin_i),
    .q_o       (pin_state)  // R13
  );

  assign hit_id   = (reg_addr_i == pcgpio_pkg::OFS_ID);
  assign hit_data = (reg_addr_i == pcgpio_pkg::OFS_DATA);
  assign hit_ctrl = (reg_addr_i == pcgpio_pkg::OFS_CTRL);
  // the identification register has no write path at all
  assign wr_data  = reg_wr_i && hit_data;
  assign wr_ctrl  = reg_wr_i && hit_ctrl;

  assign id_word   = {DEVICE_IDENTIFIER, REVISION_IDENTIFIER};  // R1 R2
  assign data_word = {16'h0000, pin_state, output_level_reg};  // R3 R6 R12
  assign ctrl_word = {8'h00, pull_direction_reg, weak_pull_mode_reg,
                      pin_direction_reg};  // R11

  // input pins keep their stored level so a later turn to output is glitch free
  assign output_level_next =
    (pick_byte(reg_wdata_i, pcgpio_pkg::DATA_LEVEL_LSB) & pin_direction_reg) |
    (output_level_reg & ~pin_direction_reg);  // R5

  assign pull_up_next   = weak_pull_mode_reg & pin_direction_reg &
                          pull_direction_reg;  // R10
  assign pull_down_next = weak_pull_mode_reg & pin_direction_reg &
                          ~pull_direction_reg;  // R10

  // unmapped addresses read as zero
  assign rdata_next = hit_id   ? id_word   :
                      hit_data ? data_word :
                      hit_ctrl ? ctrl_word :
                      32'h0000_0000;

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
      output_level_reg <= pcgpio_pkg::LEVEL_RESET;  // R12
    else if (wr_data)
      output_level_reg <= output_level_next;  // R4
  end

  // reserved bits 31..24 are not stored
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_direction_reg  <= pcgpio_pkg::DIR_RESET;  // R11
      weak_pull_mode_reg <= pcgpio_pkg::MODE_RESET;
      pull_direction_reg <= pcgpio_pkg::PULL_RESET;
    end
    else if (wr_ctrl)
    begin
      pin_direction_reg  <= pick_byte(reg_wdata_i, pcgpio_pkg::CTRL_DIR_LSB);  // R7
      weak_pull_mode_reg <= pick_byte(reg_wdata_i, pcgpio_pkg::CTRL_MODE_LSB);  // R8
      pull_direction_reg <= pick_byte(reg_wdata_i, pcgpio_pkg::CTRL_PULL_LSB);  // R9
    end
  end

  // pull enables lag the control write by one cycle
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pull_up_en_o   <= 8'h00;
      pull_down_en_o <= 8'h00;
    end
    else
    begin
      pull_up_en_o   <= pull_up_next;
      pull_down_en_o <= pull_down_next;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata_o  <= pcgpio_pkg::RDATA_RESET;
      reg_rvalid_o <= 1'b0;
    end
    else
    begin
      reg_rdata_o  <= reg_rd_i ? rdata_next : reg_rdata_o;
      reg_rvalid_o <= reg_rd_i;
    end
  end

  assign io_pin_o    = output_level_reg;  // R4
  assign io_pin_oe_o = pin_direction_reg;  // R7

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n);

  sequence s_read_id;
    reg_rd_i && hit_id;
  endsequence

  sequence s_ctrl_write;
    wr_ctrl ##1 !wr_ctrl;
  endsequence

  property p_id_device;
    s_read_id |=> reg_rvalid_o && reg_rdata_o[31:16] == DEVICE_IDENTIFIER;
  endproperty
  a_id_device: assert property (p_id_device)  // R1
    else $error("device identifier field wrong");

  property p_id_revision;
    s_read_id |=> reg_rdata_o[15:0] == REVISION_IDENTIFIER;
  endproperty
  a_id_revision: assert property (p_id_revision)  // R2
    else $error("revision identifier field wrong");

  property p_pin_state_read;
    reg_rd_i && hit_data |=> reg_rdata_o[15:8] == $past(pin_state);
  endproperty
  a_pin_state_read: assert property (p_pin_state_read)  // R3
    else $error("pin state bits do not match sampled pins");

  property p_output_drive;
    wr_data |=> ((io_pin_o ^ $past(reg_wdata_i[7:0])) & io_pin_oe_o) == 8'h00;
  endproperty
  a_output_drive: assert property (p_output_drive)  // R4
    else $error("output pin level differs from written value");

  property p_input_ignores_write;
    wr_data |=> ((io_pin_o ^ $past(io_pin_o)) & ~$past(io_pin_oe_o)) == 8'h00;
  endproperty
  a_input_ignores_write: assert property (p_input_ignores_write)  // R5
    else $error("level bit of input pin changed on write");

  property p_level_readback;
    wr_data ##1 (reg_rd_i && hit_data && !reg_wr_i) |=>
      (reg_rdata_o[7:0] & io_pin_oe_o) == ($past(reg_wdata_i[7:0], 2) & io_pin_oe_o);
  endproperty
  a_level_readback: assert property (p_level_readback)  // R6
    else $error("output level readback not last written value");

  property p_direction_set;
    wr_ctrl |=> io_pin_oe_o == $past(reg_wdata_i[7:0]);
  endproperty
  a_direction_set: assert property (p_direction_set)  // R7
    else $error("direction not taken from control write");

  property p_pull_needs_mode;
    ((pull_up_en_o | pull_down_en_o) & ~weak_pull_mode_reg) != 8'h00 |-> $past(wr_ctrl);
  endproperty
  a_pull_needs_mode: assert property (p_pull_needs_mode)  // R8
    else $error("weak pull active in normal mode");

  property p_pull_select;
    s_ctrl_write |=> pull_up_en_o == ($past(reg_wdata_i[23:16], 2) &
      $past(reg_wdata_i[15:8], 2) & $past(reg_wdata_i[7:0], 2)) &&
      pull_down_en_o == (~$past(reg_wdata_i[23:16], 2) &
      $past(reg_wdata_i[15:8], 2) & $past(reg_wdata_i[7:0], 2));
  endproperty
  a_pull_select: assert property (p_pull_select)  // R9
    else $error("pull direction not as written");

  property p_pull_needs_output;
    !$past(wr_ctrl) |-> ((pull_up_en_o | pull_down_en_o) & ~io_pin_oe_o) == 8'h00;
  endproperty
  a_pull_needs_output: assert property (p_pull_needs_output)  // R10
    else $error("weak pull active on input pin");

  property p_ctrl_reserved;
    reg_rd_i && hit_ctrl |=> reg_rdata_o[31:24] == 8'h00;
  endproperty
  a_ctrl_reserved: assert property (p_ctrl_reserved)  // R11
    else $error("control reserved bits not zero");

  property p_data_reserved;
    reg_rd_i && hit_data |=> reg_rdata_o[31:16] == 16'h0000;
  endproperty
  a_data_reserved: assert property (p_data_reserved)  // R12
    else $error("data reserved bits not zero");

  property p_pin_sync_delay;
    $past(rst_n, 2) |-> pin_state == $past(io_pin_i, 2);
  endproperty
  a_pin_sync_delay: assert property (p_pin_sync_delay)  // R13
    else $error("pin state not two cycles behind pins");

  property p_read_answer;
    reg_rd_i |=> reg_rvalid_o ##1 (reg_rvalid_o == $past(reg_rd_i));
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read answer timing wrong");

  sequence s_ctrl_write_read;
    wr_ctrl ##1 (reg_rd_i && hit_ctrl && !reg_wr_i);
  endsequence

  property p_ctrl_readback;
    s_ctrl_write_read |=> reg_rdata_o[23:0] == $past(reg_wdata_i[23:0], 2);
  endproperty
  a_ctrl_readback: assert property (p_ctrl_readback)  // R9
    else $error("control readback not last written value");

  property p_reset_outputs_clear;
    $rose(rst_n) |-> io_pin_o == 8'h00 && io_pin_oe_o == 8'h00 &&
      pull_up_en_o == 8'h00 && pull_down_en_o == 8'h00;
  endproperty
  a_reset_outputs_clear: assert property (p_reset_outputs_clear)  // R12
    else $error("pin outputs not cleared by reset");

  property p_data_write_keeps_dir;
    wr_data |=> $stable(io_pin_oe_o);
  endproperty
  a_data_write_keeps_dir: assert property (p_data_write_keeps_dir)  // R7
    else $error("data write changed pin direction");

  property p_ctrl_write_keeps_levels;
    wr_ctrl |=> $stable(io_pin_o);
  endproperty
  a_ctrl_write_keeps_levels: assert property (p_ctrl_write_keeps_levels)  // R4
    else $error("control write changed output levels");

  // unmapped places must never leak a stale register value
  property p_unmapped_zero;
    reg_rd_i && !(hit_id || hit_data || hit_ctrl) |=> reg_rdata_o == 32'h0000_0000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read not zero");

  property p_rdata_hold;
    !reg_rd_i |=> $stable(reg_rdata_o);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data changed without a read");

  property p_rvalid_needs_read;
    reg_rvalid_o |-> $past(reg_rd_i);
  endproperty
  a_rvalid_needs_read: assert property (p_rvalid_needs_read)
    else $error("read answer without a read");

endmodule : pcgpio_port

// ---- pcgpio_pkg.sv ----
package pcgpio_pkg;
  localparam int          ADDR_W         = 12;
  localparam int          DATA_W         = 32;
  localparam int          PIN_COUNT      = 8;
  localparam int          SYNC_STAGES    = 2;

  // byte addresses of the three registers
  localparam logic [11:0] OFS_ID         = 12'h430;
  localparam logic [11:0] OFS_DATA       = 12'h434;
  localparam logic [11:0] OFS_CTRL       = 12'h438;

  // identification word layout
  localparam int          ID_DEV_LSB     = 16;
  localparam int          ID_REV_LSB     = 0;

  // data word layout
  localparam int          DATA_LEVEL_LSB = 0;
  localparam int          DATA_STATE_LSB = 8;

  // control word layout
  localparam int          CTRL_DIR_LSB   = 0;
  localparam int          CTRL_MODE_LSB  = 8;
  localparam int          CTRL_PULL_LSB  = 16;

  // reset values
  localparam logic [7:0]  LEVEL_RESET    = 8'h00;
  localparam logic [7:0]  DIR_RESET      = 8'h00;
  localparam logic [7:0]  MODE_RESET     = 8'h00;
  localparam logic [7:0]  PULL_RESET     = 8'h00;
  localparam logic [31:0] RDATA_RESET    = 32'h0000_0000;
endpackage : pcgpio_pkg

// ---- pcgpio_sync.sv ----
`timescale 1ns/100ps
module pcgpio_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] stage1_reg;

  if (WIDTH < 1)
  begin : g_width_check
    $error("pcgpio_sync: WIDTH must be at least 1");
  end

  // stage1_reg feeds only the second flop
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      stage1_reg <= '0;
      q_o        <= '0;
    end
    else
    begin
      stage1_reg <= d_i;
      q_o        <= stage1_reg;
    end
  end
endmodule : pcgpio_sync

// ---- pcgpio_pins.sv ----
`timescale 1ns/100ps
module pcgpio_pins (
  input  wire logic       clk_i,
  input  wire logic [7:0] level_i,
  input  wire logic [7:0] drive_en_i,
  input  wire logic [7:0] pull_up_i,
  input  wire logic [7:0] pull_down_i,
  input  wire logic [7:0] ext_val_i,
  input  wire logic [7:0] ext_en_i,
  output logic      [7:0] pad_o
);
  logic [7:0] float_reg = 8'h5a;
  logic [7:0] free_w;

  // an undriven pin wanders every cycle so no stale level is trusted
  always_ff @(posedge clk_i)
  begin
    float_reg <= ~float_reg;
  end

  assign free_w = ~drive_en_i & ~ext_en_i;
  assign pad_o  = (drive_en_i & level_i) | (~drive_en_i & ext_en_i & ext_val_i)
                | (free_w & pull_up_i)
                | (free_w & ~pull_up_i & ~pull_down_i & float_reg);
endmodule : pcgpio_pins

// ---- pcgpio_port_tb.sv ----
`timescale 1ns/100ps
module pcgpio_port_tb;
  localparam logic [15:0] DEV_P = 16'h3c07; // arbitrary value
  localparam logic [15:0] REV_P = 16'h0002; // arbitrary value
  logic        clk_i       = 1'b0;
  logic        reset_n_i   = 1'b0;
  logic [11:0] reg_addr_i  = 12'h000;
  logic        reg_wr_i    = 1'b0;
  logic        reg_rd_i    = 1'b0;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic [31:0] reg_rdata_o;
  logic        reg_rvalid_o;
  logic [7:0]  io_pin_i, io_pin_o, io_pin_oe_o, pull_up_en_o, pull_down_en_o;
  logic [7:0]  ext_val     = 8'h00;
  logic [31:0] seed        = 32'h0686bada;
  logic [31:0] rd_val, w;
  int          error_cnt   = 0;
  int          comparisons = 0;
  int          ctrl_m      = 0;
  int          lev_m       = 0;
  logic [11:0] odd_addr [3] = '{12'h43c, 12'h431, 12'h42c};

  always #5 clk_i = ~clk_i;

  pcgpio_port #(.DEVICE_IDENTIFIER(DEV_P), .REVISION_IDENTIFIER(REV_P)) i_pcgpio_port (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .reg_rvalid_o(reg_rvalid_o), .io_pin_i(io_pin_i), .io_pin_o(io_pin_o),
    .io_pin_oe_o(io_pin_oe_o), .pull_up_en_o(pull_up_en_o), .pull_down_en_o(pull_down_en_o));

  pcgpio_pins i_pcgpio_pins (
    .clk_i(clk_i), .level_i(io_pin_o), .drive_en_i(io_pin_oe_o),
    .pull_up_i(pull_up_en_o), .pull_down_i(pull_down_en_o),
    .ext_val_i(ext_val), .ext_en_i(8'hff), .pad_o(io_pin_i));

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i   <= 1'b1;
    @(posedge clk_i);
    reg_rd_i   <= 1'b0;
    #1;
    for (int n = 0; n < 3 && reg_rvalid_o !== 1'b1; n++)
      @(posedge clk_i) #1;
    chk("rvalid", {31'h0, reg_rvalid_o}, 32'h1);
    rd_val = reg_rdata_o;
  endtask : rd

  // write then read the same place on the very next cycle
  task automatic wr_rd(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_wr_i    <= 1'b1;
    @(posedge clk_i);
    reg_wr_i    <= 1'b0;
    reg_rd_i    <= 1'b1;
    @(posedge clk_i);
    reg_rd_i    <= 1'b0;
    #1;
    chk("rvalid", {31'h0, reg_rvalid_o}, 32'h1);
    rd_val = reg_rdata_o;
  endtask : wr_rd

  // model of the pads and registers, integers only
  task automatic check_pins();
    int dir, pin;
    dir = ctrl_m & 8'hff;
    pin = (dir & lev_m) | (~dir & ext_val);
    chk("direction", {24'h0, io_pin_oe_o}, dir);
    chk("level", {24'h0, io_pin_o}, lev_m);
    chk("pull_up", {24'h0, pull_up_en_o}, (ctrl_m >> 8) & dir & (ctrl_m >> 16) & 8'hff);
    chk("pull_down", {24'h0, pull_down_en_o}, (ctrl_m >> 8) & dir & ~(ctrl_m >> 16) & 8'hff);
    rd(pcgpio_pkg::OFS_CTRL);
    chk("control", rd_val, ctrl_m);
    rd(pcgpio_pkg::OFS_DATA);
    chk("data", rd_val, ((pin & 8'hff) << 8) | lev_m);
  endtask : check_pins

  task automatic end_of_test();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  initial
  begin
    #200000;
    error_cnt++;
    end_of_test();
  end

  initial
  begin
    repeat (6) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    check_pins();
    w = rnd();
    wr(pcgpio_pkg::OFS_ID, w);
    rd(pcgpio_pkg::OFS_ID);
    chk("ident", rd_val, {DEV_P, REV_P});
    // unmapped and unaligned places read zero and swallow writes
    foreach (odd_addr[k])
    begin
      wr(odd_addr[k], rnd());
      rd(odd_addr[k]);
      chk("unmapped", rd_val, 32'h0);
    end
    for (int i = 0; i < 24; i++)
    begin
      w = rnd();
      ext_val <= w[15:8];
      wr_rd(pcgpio_pkg::OFS_CTRL, w);
      ctrl_m = w & 32'h00ff_ffff;
      chk("ctrl_readback", rd_val, ctrl_m);
      w = rnd();
      wr_rd(pcgpio_pkg::OFS_DATA, w);
      lev_m = (lev_m & ~ctrl_m & 8'hff) | (w & ctrl_m & 8'hff);
      chk("readback", rd_val & 32'h0000_00ff, lev_m);
      repeat (2) @(posedge clk_i);
      #1 check_pins();
    end
    // second reset in mid-run clears control and levels
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    ctrl_m = 0;
    lev_m  = 0;
    #1 check_pins();
    end_of_test();
  end
endmodule : pcgpio_port_tb
